// ==== hdl/board_error_pkg.sv ====
// Purpose: Constants for the board error information register bank
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Status word is sticky; interrupt status clears by writing one
`default_nettype none

package board_error_pkg;

    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ERRINFO_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'hC;

    localparam int BIT_WDT = 0;
    localparam int BIT_BUS = 1;
    localparam int BIT_CYC_PROC = 2;
    localparam int BIT_FLASH_DB = 3;
    localparam int BIT_INCOMPAT = 4;
    localparam int BIT_CYC_BOARD = 5;
    localparam int BIT_HIGH_LOAD = 8;
    localparam int BIT_OP_CYCLE = 9;
    localparam int WORD_W = 16;

    localparam logic [15:0] ERRINFO_RESET = 16'h0000;
    localparam logic [15:0] USED_BITS = 16'h033F;

    localparam int LOAD_LIMIT_PCT = 80;
    localparam int LOAD_RUN_LEN = 3;
    localparam int HOST_CYCLE_PCT = 20;

    localparam int CTL_DUPLEX = 0;
    localparam int CTL_PROC_VARIANT = 1;

endpackage : board_error_pkg

`default_nettype wire

// ==== hdl/board_error_regs.sv ====
// Purpose: Error information word of the loop controller board, on Wishbone
// Assumes: Single clock; event inputs are synchronous one-cycle or level inputs
// Notes: Flags hold until reset (board restart); word is read-only
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`default_nettype none

// How it works
// [RULE_01] Watchdog failure input sets bit 00; reads zero otherwise.
// [RULE_02] Board bus error input sets bit 01.
// [RULE_03] Token not returned within monitor time sets bit 02 or 05 by variant.
// [RULE_04] Flash data check failure at cold start sets bit 03.
// [RULE_05] In duplex mode, all function block databases bad also sets bit 03.
// [RULE_06] Mounting in an unsupported host sets bit 04.
// [RULE_07] Load above 80 percent for three consecutive cycles sets bit 08.
// [RULE_08] Duplex host cycle above 20 percent of minimum operation cycle sets bit 09.
// [RULE_09] Bits 06 and 07 are never used and read zero.
// [RULE_10] Flags stay set until restart; the word ignores writes.
module board_error_regs
    import board_error_pkg::*;
#(
    parameter int CYCLE_W = 24,
    parameter int MON_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic wdt_fail_i,
    input wire logic bus_error_i,
    input wire logic token_taken_i,
    input wire logic token_returned_i,
    input wire logic [MON_W-1:0] monitor_time_i,
    input wire logic flash_check_done_i,
    input wire logic flash_check_bad_i,
    input wire logic all_fb_db_bad_i,
    input wire logic unsupported_host_i,
    input wire logic op_cycle_end_i,
    input wire logic [6:0] load_pct_i,
    input wire logic host_cycle_valid_i,
    input wire logic [CYCLE_W-1:0] host_cycle_i,
    input wire logic [CYCLE_W-1:0] min_op_cycle_i,
    output logic [WORD_W-1:0] board_error_information_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [WORD_W-1:0] errinfo_ff;
    logic [WORD_W-1:0] nxt_errinfo;
    logic [WORD_W-1:0] int_status_ff;
    logic [WORD_W-1:0] int_mask_ff;
    logic [1:0] control_ff;
    logic [MON_W-1:0] mon_cnt_ff;
    logic token_out_ff;
    logic [1:0] load_run_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] dat_ff;
    logic [WORD_W-1:0] set_vec;
    logic cyc_timeout;
    logic load_high;
    logic host_slow;
    logic req;
    logic duplex;

    assign duplex = control_ff[CTL_DUPLEX];
    assign req = cyc_i && stb_i && !ack_ff && !err_ff;

    function automatic logic byte_lanes_ok(input logic [3:0] sel);
        byte_lanes_ok = (sel[1:0] == 2'b11);
    endfunction : byte_lanes_ok

    ////////////////////////////////////////////////////////////////////////
    // Cyclic area token monitor
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            token_out_ff <= 1'b0;
            mon_cnt_ff <= '0;
        end else if (token_returned_i) begin
            token_out_ff <= 1'b0;
            mon_cnt_ff <= '0;
        end else if (token_taken_i) begin
            token_out_ff <= 1'b1;
            mon_cnt_ff <= '0;
        end else if (token_out_ff && !cyc_timeout) begin
            mon_cnt_ff <= mon_cnt_ff + 1'b1;
        end
    end

    assign cyc_timeout = token_out_ff && (mon_cnt_ff >= monitor_time_i); // [RULE_03]

    a_token_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        token_taken_i && !token_returned_i |=> token_out_ff && mon_cnt_ff == '0)
        else $error("token monitor did not start");
    a_token_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        token_returned_i |=> !token_out_ff)
        else $error("token monitor did not stop");
    a_mon_counts: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        token_out_ff && !cyc_timeout && !token_taken_i && !token_returned_i
        |=> mon_cnt_ff == $past(mon_cnt_ff) + 1'b1)
        else $error("monitor count did not advance");
    a_mon_holds: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        cyc_timeout && !token_taken_i && !token_returned_i
        |=> cyc_timeout || $changed(monitor_time_i))
        else $error("overdue token timeout dropped");
    a_proc_variant: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        cyc_timeout && control_ff[CTL_PROC_VARIANT] |=> errinfo_ff[BIT_CYC_PROC])
        else $error("process variant monitor flag not set");
    a_variant_excl: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        cyc_timeout && control_ff[CTL_PROC_VARIANT] && !errinfo_ff[BIT_CYC_BOARD]
        |=> !errinfo_ff[BIT_CYC_BOARD])
        else $error("board monitor flag set on process variant");

    ////////////////////////////////////////////////////////////////////////
    // Load rate run counter
    assign load_high = (load_pct_i > 7'(LOAD_LIMIT_PCT));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_run_ff <= 2'd0;
        end else if (op_cycle_end_i) begin
            if (!load_high) begin
                load_run_ff <= 2'd0;
            end else if (load_run_ff != 2'(LOAD_RUN_LEN)) begin
                load_run_ff <= load_run_ff + 2'd1; // [RULE_07]
            end
        end
    end

    a_load_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        op_cycle_end_i && !load_high |=> load_run_ff == 2'd0)
        else $error("load run not cleared");
    a_load_step: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        op_cycle_end_i && load_high && load_run_ff != 2'(LOAD_RUN_LEN)
        |=> load_run_ff == $past(load_run_ff) + 2'd1)
        else $error("load run did not advance");
    a_load_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        !op_cycle_end_i |=> $stable(load_run_ff))
        else $error("load run moved between cycles");
    a_load_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        op_cycle_end_i && load_high && load_run_ff == 2'd2 |=> errinfo_ff[BIT_HIGH_LOAD])
        else $error("high load flag not set");
    a_load_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        op_cycle_end_i && !load_high && !errinfo_ff[BIT_HIGH_LOAD]
        |=> !errinfo_ff[BIT_HIGH_LOAD])
        else $error("high load flag set on low load");

    // host*100 > min*20, evaluated without division
    assign host_slow = host_cycle_valid_i && duplex
        && ((CYCLE_W + 7)'(host_cycle_i) * (CYCLE_W + 7)'(100)
            > (CYCLE_W + 7)'(min_op_cycle_i) * (CYCLE_W + 7)'(HOST_CYCLE_PCT)); // [RULE_08]

    a_op_simplex: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        !duplex && !errinfo_ff[BIT_OP_CYCLE] |=> !errinfo_ff[BIT_OP_CYCLE])
        else $error("operation cycle flag set in simplex");
    a_op_within: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        duplex && host_cycle_valid_i && !errinfo_ff[BIT_OP_CYCLE]
        && {3'b000, host_cycle_i} * 3'd5 <= {3'b000, min_op_cycle_i}
        |=> !errinfo_ff[BIT_OP_CYCLE])
        else $error("operation cycle flag set within limit");
    a_op_exceeds: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        duplex && host_cycle_valid_i
        && {3'b000, host_cycle_i} * 3'd5 > {3'b000, min_op_cycle_i}
        |=> errinfo_ff[BIT_OP_CYCLE])
        else $error("operation cycle flag not set");

    ////////////////////////////////////////////////////////////////////////
    // Flag set terms
    always_comb begin
        set_vec = '0;
        set_vec[BIT_WDT] = wdt_fail_i; // [RULE_01]
        set_vec[BIT_BUS] = bus_error_i; // [RULE_02]
        set_vec[BIT_CYC_PROC] = cyc_timeout && control_ff[CTL_PROC_VARIANT]; // [RULE_03]
        set_vec[BIT_CYC_BOARD] = cyc_timeout && !control_ff[CTL_PROC_VARIANT]; // [RULE_03]
        set_vec[BIT_FLASH_DB] = (flash_check_done_i && flash_check_bad_i) // [RULE_04]
            || (duplex && all_fb_db_bad_i); // [RULE_05]
        set_vec[BIT_INCOMPAT] = unsupported_host_i; // [RULE_06]
        set_vec[BIT_HIGH_LOAD] = op_cycle_end_i && load_high
            && (load_run_ff == 2'(LOAD_RUN_LEN - 1)); // [RULE_07]
        set_vec[BIT_OP_CYCLE] = host_slow; // [RULE_08]
        set_vec = set_vec & USED_BITS; // [RULE_09]
    end

    assign nxt_errinfo = errinfo_ff | set_vec;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            errinfo_ff <= ERRINFO_RESET;
        end else begin
            errinfo_ff <= nxt_errinfo; // [RULE_10]
        end
    end

    assign board_error_information_o = errinfo_ff;

    a_set_lands: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        set_vec != '0 |=> (errinfo_ff & $past(set_vec)) == $past(set_vec))
        else $error("raised flag did not land");
    a_reset_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        $past(rst_i) |-> errinfo_ff == ERRINFO_RESET)
        else $error("error word not cleared by restart");
    a_wdt_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        !errinfo_ff[BIT_WDT] && !wdt_fail_i |=> !errinfo_ff[BIT_WDT])
        else $error("watchdog flag set without failure");
    a_bus_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
        !errinfo_ff[BIT_BUS] && !bus_error_i |=> !errinfo_ff[BIT_BUS])
        else $error("bus error flag set without error");
    a_incompat_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        !errinfo_ff[BIT_INCOMPAT] && !unsupported_host_i |=> !errinfo_ff[BIT_INCOMPAT])
        else $error("incompatible host flag set without cause");
    a_flash_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        !flash_check_done_i && !(duplex && all_fb_db_bad_i) && !errinfo_ff[BIT_FLASH_DB]
        |=> !errinfo_ff[BIT_FLASH_DB])
        else $error("flash flag set without check");
    a_duplex_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        duplex && all_fb_db_bad_i |=> errinfo_ff[BIT_FLASH_DB])
        else $error("database flag not set in duplex");
    a_upper_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        errinfo_ff[WORD_W-1:10] == '0)
        else $error("upper error bits set");

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, newly raised flags; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_status_ff <= '0;
        end else if (req && we_i && adr_i == INT_STATUS_OFS && byte_lanes_ok(sel_i)) begin
            int_status_ff <= (int_status_ff & ~dat_i[WORD_W-1:0]) | (set_vec & ~errinfo_ff);
        end else begin
            int_status_ff <= int_status_ff | (set_vec & ~errinfo_ff);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_mask_ff <= '0;
            control_ff <= 2'b00;
        end else if (req && we_i && byte_lanes_ok(sel_i)) begin
            if (adr_i == INT_MASK_OFS) begin
                int_mask_ff <= dat_i[WORD_W-1:0] & USED_BITS;
            end else if (adr_i == CONTROL_OFS) begin
                control_ff <= dat_i[1:0];
            end
        end
    end

    assign irq_o = |(int_status_ff & int_mask_ff);

    a_status_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_vec & ~errinfo_ff) != '0
        |=> (int_status_ff & $past(set_vec & ~errinfo_ff)) == $past(set_vec & ~errinfo_ff))
        else $error("status bit not set on new flag");
    a_status_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
        req && we_i && adr_i == INT_STATUS_OFS && byte_lanes_ok(sel_i)
        && (set_vec & ~errinfo_ff) == '0 |=> (int_status_ff & $past(dat_i[WORD_W-1:0])) == '0)
        else $error("status bit not cleared by write");
    a_status_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !req && (set_vec & ~errinfo_ff) == '0 |=> int_status_ff == $past(int_status_ff))
        else $error("status changed without cause");
    a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
        req && we_i && adr_i == INT_MASK_OFS && byte_lanes_ok(sel_i)
        |=> int_mask_ff == ($past(dat_i[WORD_W-1:0]) & USED_BITS))
        else $error("mask write lost");
    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        req && we_i && adr_i == CONTROL_OFS && byte_lanes_ok(sel_i)
        |=> control_ff == $past(dat_i[1:0]))
        else $error("control write lost");

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after request, err on unmapped address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            if (req) begin
                if (adr_i == ERRINFO_OFS) begin
                    ack_ff <= 1'b1;
                    dat_ff <= {16'h0000, errinfo_ff}; // [RULE_10]
                end else if (adr_i == INT_STATUS_OFS) begin
                    ack_ff <= 1'b1;
                    dat_ff <= {16'h0000, int_status_ff};
                end else if (adr_i == INT_MASK_OFS) begin
                    ack_ff <= 1'b1;
                    dat_ff <= {16'h0000, int_mask_ff};
                end else if (adr_i == CONTROL_OFS) begin
                    ack_ff <= 1'b1;
                    dat_ff <= {30'h0000_0000, control_ff};
                end else begin
                    err_ff <= 1'b1;
                    dat_ff <= '0;
                end
            end
        end
    end

    assign ack_o = ack_ff;
    assign err_o = err_ff;
    assign dat_o = dat_ff;

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_err_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("err longer than one cycle");
    a_answer_once: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> !err_o)
        else $error("ack and err together");
    a_req_answered: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o || err_o)
        else $error("request not answered");
    a_answer_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o || err_o |-> $past(req))
        else $error("answer without request");
    a_read_word: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        req && !we_i && adr_i == ERRINFO_OFS |=> dat_o == {16'h0000, $past(errinfo_ff)})
        else $error("error word read wrong");
    a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        req && adr_i != ERRINFO_OFS && adr_i != INT_STATUS_OFS
        && adr_i != INT_MASK_OFS && adr_i != CONTROL_OFS |=> err_o && !ack_o)
        else $error("unmapped address not refused");
    a_upper_data: assert property (@(posedge clk_i) disable iff (rst_i)
        dat_o[31:WORD_W] == '0)
        else $error("upper read data not zero");

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_flags_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        &($past(errinfo_ff) & ~($past(errinfo_ff) & ~errinfo_ff)) || $past(errinfo_ff) == '0
        || ((errinfo_ff & $past(errinfo_ff)) == $past(errinfo_ff)))
        else $error("error flag cleared without reset");
    a_wdt_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        wdt_fail_i |=> errinfo_ff[BIT_WDT])
        else $error("watchdog flag not set");
    a_bus_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
        bus_error_i |=> errinfo_ff[BIT_BUS])
        else $error("bus error flag not set");
    a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        errinfo_ff[7:6] == 2'b00)
        else $error("unused bits set");
    a_flash_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        flash_check_done_i && flash_check_bad_i |=> errinfo_ff[BIT_FLASH_DB])
        else $error("flash flag not set");
    a_duplex_db: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        !duplex && !flash_check_done_i && !errinfo_ff[BIT_FLASH_DB] && all_fb_db_bad_i
        |=> !errinfo_ff[BIT_FLASH_DB])
        else $error("database flag set outside duplex");
    a_incompat_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        unsupported_host_i |=> errinfo_ff[BIT_INCOMPAT])
        else $error("incompatible host flag not set");
    a_load_three: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        $rose(errinfo_ff[BIT_HIGH_LOAD]) |-> $past(load_run_ff) == 2'd2 && $past(load_high))
        else $error("high load flag set too early");
    a_monitor_variant: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        cyc_timeout && !control_ff[CTL_PROC_VARIANT] |=> errinfo_ff[BIT_CYC_BOARD])
        else $error("cyclic monitor flag not set");
    a_host_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        $rose(errinfo_ff[BIT_OP_CYCLE]) |-> $past(duplex) && $past(host_cycle_valid_i))
        else $error("operation cycle flag without cause");

endmodule : board_error_regs

`default_nettype wire

// ==== test/board_error_regs_bench.sv ====
// Purpose: Self-checking bench for the board error information bank
// Assumes: Monitor time shortened to 8 cycles
// Notes: Board is restarted between sticky flag scenarios
`default_nettype none
module board_error_regs_bench import board_error_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o, berr, wdt, bus, tok, ret;
    logic unsup, fbdb, hvalid, opend, fdone, fbad;
    logic [ADDR_W-1:0] adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [6:0] load;
    logic [23:0] mon, hcyc, mincyc;
    logic [15:0] word;
    logic [7:0] delay;
    int err_total = 0;
    int comparisons = 0;
    int ticks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    board_error_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .wdt_fail_i(wdt), .bus_error_i(bus),
        .token_taken_i(tok), .token_returned_i(ret), .monitor_time_i(mon),
        .flash_check_done_i(fdone), .flash_check_bad_i(fbad), .all_fb_db_bad_i(fbdb),
        .unsupported_host_i(unsup), .op_cycle_end_i(opend), .load_pct_i(load),
        .host_cycle_valid_i(hvalid), .host_cycle_i(hcyc), .min_op_cycle_i(mincyc),
        .board_error_information_o(word), .irq_o(irq_o));
    host_token_model host (.clk_i(clk_i), .token_taken_i(tok), .ret_delay_i(delay),
        .token_returned_o(ret));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        rd = dat_o;
        berr = err_o;
        {cyc_i, stb_i} <= 2'b00;
        chk("bus answer", 32'(n < 50), 32'h1);
    endtask : wb
    // Bits: wdt, bus, token, unsupported, fb database, host cycle, op end, flash done
    task automatic fire(input logic [7:0] m);
        @(posedge clk_i);
        {wdt, bus, tok, unsup, fbdb, hvalid, opend, fdone} <= m;
        @(posedge clk_i);
        {wdt, bus, tok, unsup, fbdb, hvalid, opend, fdone} <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask : fire
    task automatic restart();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : restart
    task automatic complete_run();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a < 16; a += 4) begin
            wb(1'b0, 4'(a), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        wb(1'b0, 4'h6, 32'h0);
        chk("unmapped err", 32'(berr), 32'h1);
        wb(1'b1, INT_MASK_OFS, 32'h1);
        fire(8'h80);
        chk("wdt word", 32'(word), 32'h1);
        chk("irq set", 32'(irq_o), 32'h1);
        fire(8'h40);
        chk("bus word", 32'(word), 32'h3);
        wb(1'b0, INT_STATUS_OFS, 32'h0);
        chk("status", rd, 32'h3);
        wb(1'b1, INT_STATUS_OFS, 32'h1);
        chk("irq clear", 32'(irq_o), 32'h0);
        wb(1'b1, ERRINFO_OFS, 32'h0);
        wb(1'b0, ERRINFO_OFS, 32'h0);
        chk("word read only", rd, 32'h3);
        $display("register and interrupt test done");
    endtask : t_regs
    task automatic t_token();
        restart();
        fire(8'h20);
        repeat (15) @(posedge clk_i);
        chk("token in time", 32'(word), 32'h0);
        delay <= 8'd30;
        fire(8'h20);
        repeat (40) @(posedge clk_i);
        chk("board timeout", 32'(word), 32'h20);
        restart();
        wb(1'b1, CONTROL_OFS, 32'h2);
        fire(8'h20);
        repeat (15) @(posedge clk_i);
        chk("proc timeout", 32'(word), 32'h4);
        $display("token monitor test done");
    endtask : t_token
    task automatic t_load_cycle();
        logic [6:0] pct [6] = '{7'd81, 7'd81, 7'd80, 7'd81, 7'd81, 7'd81};
        restart();
        foreach (pct[i]) begin
            load <= pct[i];
            fire(8'h02);
            chk("load flag", 32'(word[8]), 32'(i == 5));
        end
        hcyc <= 24'd30;
        fire(8'h04);
        wb(1'b1, CONTROL_OFS, 32'h1);
        hcyc <= 24'd20;
        fire(8'h04);
        chk("cycle limit", 32'(word), 32'h100);
        hcyc <= 24'd21;
        fire(8'h14);
        fire(8'h08);
        chk("cycle unsup fb", 32'(word), 32'h318);
        chk("unused bits", 32'(word & ~USED_BITS), 32'h0);
        restart();
        fire(8'h08);
        fire(8'h01);
        chk("simplex and good flash", 32'(word), 32'h0);
        fbad <= 1'b1;
        fire(8'h01);
        chk("bad flash", 32'(word), 32'h8);
        $display("load, cycle and flash test done");
    endtask : t_load_cycle
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, wdt, bus, tok, unsup} = '0;
        {fbdb, hvalid, opend, fdone, fbad, load, hcyc} = '0;
        {mon, mincyc, delay} = {24'd8, 24'd100, 8'd3};
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_token();
        t_load_cycle();
        complete_run();
    end
endmodule : board_error_regs_bench
`default_nettype wire

// ==== test/host_token_model.sv ====
// Purpose: Host CPU model that hands back the cyclic area token
// Assumes: Return delay in clock cycles is set by the bench
// Notes: Return is a one-cycle pulse
`default_nettype none
module host_token_model (
    input wire logic clk_i,
    input wire logic token_taken_i,
    input wire logic [7:0] ret_delay_i,
    output logic token_returned_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_ff = 8'h00;
    always_ff @(posedge clk_i) begin
        token_returned_o <= (cnt_ff == 8'h01);
        if (token_taken_i) begin
            cnt_ff <= ret_delay_i;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
endmodule : host_token_model
`default_nettype wire
